// file: scr_chan.sv
// one channel's write registers, enables and line state
`timescale 1ns/1ps
`include "scr_map.svh"
module scr_chan (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic chan_rst_i, // channel or full reset pulse
  input wire logic full_rst_i, // full reset pulse
  input wire logic we_i, // write strobe to pointer register
  input wire logic [3:0] ptr_i,
  input wire logic [7:0] wdata_i,
  input wire logic ext_clr_i, // reset external status command
  output logic rx_en_o,
  output logic tx_en_o,
  output logic txd_o,
  output logic rts_n_o,
  output logic dtr_n_o,
  output logic ip_o, // interrupt pending
  output logic ius_o, // interrupt under service
  output logic ie_o, // any interrupt enabled
  output logic [7:0] extie_o,
  output logic crc_clr_o // transmit crc reset pulse
);
  logic [7:0] irqdma_reg; // irq / dma control
  logic [7:0] rxctl_reg; // receive control
  logic [7:0] txctl_reg; // transmit control
  logic [7:0] miscclk_reg; // misc clock control
  logic [7:0] extie_reg; // ext status int enable
  logic ip_reg;
  logic ius_reg;
  logic crc_clr_reg;
  logic ext_latch_reg; // ext status latch, reopened by command
  wire wr_cmd = we_i && ptr_i == `SCR_REG_CMD;
  // register writes, reset forces safe state
  always_ff @(posedge clk_i)
  begin
    if (rst_i || chan_rst_i)
    begin
      irqdma_reg <= 8'h00; // interrupts disabled
      rxctl_reg <= 8'h00; // receiver off
      txctl_reg <= 8'h00; // transmitter off
      extie_reg <= `SCR_EXTIE_RST;
      miscclk_reg <= `SCR_MISCCLK_RST;
      ip_reg <= 1'b0;
      ius_reg <= 1'b0;
      crc_clr_reg <= 1'b0;
      ext_latch_reg <= 1'b0;
    end
    else
    begin
      crc_clr_reg <= wr_cmd && wdata_i == `SCR_CMD_RST_TXCRC;
      if (we_i && ptr_i == `SCR_REG_IRQDMA)
        irqdma_reg <= wdata_i;
      if (we_i && ptr_i == `SCR_REG_RXCTL)
        rxctl_reg <= wdata_i;
      if (we_i && ptr_i == `SCR_REG_TXCTL)
        txctl_reg <= wdata_i;
      if (we_i && ptr_i == `SCR_REG_MISCCLK)
        miscclk_reg <= wdata_i;
      if (we_i && ptr_i == `SCR_REG_EXTIE)
        extie_reg <= wdata_i;
      // ext status latch reopens on command
      if (ext_clr_i)
        ext_latch_reg <= 1'b0;
    end
  end
  // full and channel reset alike load 20h into the misc clock register, brg off
  assign rx_en_o = rxctl_reg[`SCR_RX_ENABLE];
  assign tx_en_o = txctl_reg[`SCR_TX_ENABLE];
  assign txd_o = 1'b1; // marking while idle or reset
  assign rts_n_o = ~txctl_reg[`SCR_TX_RTS]; // high after reset
  assign dtr_n_o = ~txctl_reg[`SCR_TX_DTR];
  assign ip_o = ip_reg;
  assign ius_o = ius_reg;
  assign ie_o = |irqdma_reg;
  assign extie_o = extie_reg;
  assign crc_clr_o = crc_clr_reg;
  wire unused_ok = &{1'b0, full_rst_i, miscclk_reg, ext_latch_reg};
endmodule // scr_chan

// file: scr_dev.sv
// controller end: register pointer, reset commands, intack vector
`timescale 1ns/1ps
`include "scr_map.svh"
// the controller end sees the host only through its strobes; every
// access is recognised on the first clock that shows a strobe low, so
// a strobe held for several clocks still counts as one access
// the recovery timer is shared by both channels, as the host spaces
// every access against one device, not against a channel
// a full reset comes from rst_i, from both strobes low together, or
// from the software reset value in master interrupt control; all three
// drive full_rst, though only rst_i resets the read data and its drive enable
// transmitter, receiver and clocking internals are not modelled; only
// the enables and line levels that resets act on are kept
module scr_dev (
  input wire logic clk_i,
  input wire logic rst_i,
  // parallel port: host strobes and write data in, device data out
  scr_if.dev bus,
  // per channel line state, kept visible for checks
  output logic [1:0] rx_en_o, // per channel, bit 1 is channel a
  output logic [1:0] tx_en_o,
  output logic [1:0] txd_o,
  output logic [1:0] rts_n_o,
  output logic [1:0] dtr_n_o,
  output logic [1:0] crc_clr_o,
  output logic [7:0] mic_o, // master interrupt control contents
  output logic recovering_o // recovery after reset or after any access in progress
);
  // wide enough for the longer of the two recovery counts
  localparam int REC_W = 4;
  logic [7:0] mic_reg; // master interrupt control
  logic [3:0] ptr_reg; // register pointer
  logic [REC_W-1:0] rec_reg; // recovery countdown
  logic rd_q_reg; // previous read strobe level
  logic wr_q_reg; // previous write strobe level
  logic [7:0] dout_reg; // read data
  logic oe_n_reg; // data drive enable, low drives
  logic [7:0] vector_reg; // interrupt vector
  logic [1:0] ext_clr_next;
  logic [1:0] ip_w, ius_w, ie_w;
  logic [7:0] extie_w [2];
  // the recovery counter must hold the long count
  if (`SCR_RESET_REC_PCLK >= (1 << REC_W))
  begin : g_bad_rec
    $error("recovery count too wide");
  end
  // strobe decode
  // a strobe counts only on the clock where it is first seen low and
  // only while the other strobe is high, so a hardware reset request
  // never looks like a read or a write
  wire sel = !bus.ce_n;
  wire hw_rst = !bus.rd_n && !bus.wr_n;
  wire wr_edge = sel && !bus.wr_n && wr_q_reg && bus.rd_n;
  wire rd_edge = sel && !bus.rd_n && rd_q_reg && bus.wr_n;
  wire busy = rec_reg != '0;
  wire wr_ok = wr_edge && !busy;
  wire ctl_wr = wr_ok && !bus.data_sel;
  wire wr_ptr = ctl_wr && ptr_reg == `SCR_REG_CMD;
  wire wr_mic = ctl_wr && ptr_reg == `SCR_REG_MIC;
  wire [7:0] wd = bus.host_d;
  // full reset on c0h, identical to pins
  wire sw_full = wr_mic && wd[7:6] == 2'b11;
  wire full_rst = rst_i || hw_rst || sw_full;
  // a channel reset leaves the other channel alone; the mode bits take the low five bits of the same write;
  // the shared register means one write may reset both channels
  // single channel reset acts only on a one
  wire rst_a = full_rst || (wr_mic && wd[`SCR_MIC_RST_A]);
  wire rst_b = full_rst || (wr_mic && wd[`SCR_MIC_RST_B]);
  // channel select and pointer as seen by the read mux
  wire chan_sel = bus.chan_a;
  wire [3:0] ptr_sel = ptr_reg;
  wire intack = sel && !bus.intack_n && !bus.rd_n;
  // vector suppressed when no-vector bit set
  wire drive_vec = intack && !mic_reg[`SCR_MIC_NO_VECTOR];
  // previous write and read strobe levels, kept for edge detection
  // no reset needed here: these follow the pins every clock, and the
  // host holds both strobes high while it is in reset
  always_ff @(posedge clk_i)
  begin
    rd_q_reg <= bus.rd_n;
    wr_q_reg <= bus.wr_n;
  end
  // master interrupt control register
  // command bits are never stored, so a later write of zero can neither
  // undo nor repeat a reset that has already happened
  always_ff @(posedge clk_i)
  begin
    if (full_rst)
      mic_reg <= 8'h00; // full reset clears modes
    else if (wr_mic)
      // keep command bits as zero, unused bit forced zero
      mic_reg <= wd & `SCR_MIC_MODE_MASK;
  end
  // pointer: set by command register, cleared after any read or control write
  // limitation: a read between a pointer write and its value write
  // drops the pointer, so the host must keep such pairs together
  always_ff @(posedge clk_i)
  begin
    if (full_rst)
      ptr_reg <= 4'h0;
    else if (rd_edge)
      ptr_reg <= 4'h0; // read always returns to zero
    else if (wr_ptr)
      ptr_reg <= {wd[3], wd[2:0]};
    else if (ctl_wr)
      ptr_reg <= 4'h0;
  end
  // recovery timer: eleven after reset, six after access
  // channel resets take the long count too; a few clocks are lost, but
  // every reset then follows one recovery rule
  always_ff @(posedge clk_i)
  begin
    if (full_rst || (wr_mic && |wd[7:6]))
      rec_reg <= REC_W'(`SCR_RESET_REC_PCLK);
    else if (wr_edge || rd_edge)
      rec_reg <= REC_W'(`SCR_CYCLE_REC_PCLK);
    else if (busy)
      rec_reg <= rec_reg - 1'b1;
  end
  // vector register
  // one vector serves both channels; only a full reset clears it, a
  // channel reset leaves it for the channel still in use
  always_ff @(posedge clk_i)
  begin
    if (full_rst)
      vector_reg <= `SCR_VECTOR_RST;
    else if (ctl_wr && ptr_reg == `SCR_REG_VECTOR)
      vector_reg <= wd;
  end
  // read data and drive enable
  // the byte is registered on the clock that sees the strobe; the host
  // samples it at the end of its strobe, so this latency costs nothing
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dout_reg <= 8'h00;
      oe_n_reg <= 1'b1;
    end
    else
    begin
      oe_n_reg <= !(drive_vec || (sel && !bus.rd_n && bus.wr_n &&
        bus.intack_n));
      if (drive_vec)
        dout_reg <= vector_reg;
      else if (ptr_sel == `SCR_REG_EXTIE)
        dout_reg <= chan_sel ? extie_w[1] : extie_w[0];
      else if (ptr_sel == 4'h3)
        dout_reg <= chan_sel ? {4'h0, ip_w, 2'b00} : 8'h00;
      else
        dout_reg <= {6'h00, chan_sel ? tx_en_o[1] : tx_en_o[0],
          chan_sel ? ip_w[1] : ip_w[0]};
    end
  end
  // ext status reset command per channel
  // the host sends this twice after enabling ext status sources; each
  // copy is a plain one-clock pulse, so a repeat is harmless
  assign ext_clr_next[1] = wr_ptr && chan_sel &&
    wd == `SCR_CMD_RST_EXTSTAT;
  assign ext_clr_next[0] = wr_ptr && !chan_sel &&
    wd == `SCR_CMD_RST_EXTSTAT;
  // channel instances, index 1 is channel a
  // both share the pointer; only the selected channel takes a write
  for (genvar c = 0; c < 2; c++)
  begin : g_chan
    wire chan_hit = (c == 1) ? chan_sel : !chan_sel;
    scr_chan u_chan (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .chan_rst_i((c == 1) ? rst_a : rst_b),
      .full_rst_i(full_rst),
      .we_i(ctl_wr && chan_hit),
      .ptr_i(ptr_reg),
      .wdata_i(wd),
      .ext_clr_i(ext_clr_next[c]),
      .rx_en_o(rx_en_o[c]),
      .tx_en_o(tx_en_o[c]),
      .txd_o(txd_o[c]),
      .rts_n_o(rts_n_o[c]),
      .dtr_n_o(dtr_n_o[c]),
      .ip_o(ip_w[c]),
      .ius_o(ius_w[c]),
      .ie_o(ie_w[c]),
      .extie_o(extie_w[c]),
      .crc_clr_o(crc_clr_o[c])
    );
  end
  // data and its enable both come from flip-flops, so they change on
  // the same clock edge and never show a stale byte with a new enable
  assign bus.dev_d = dout_reg;
  assign bus.dev_d_oe_n = oe_n_reg;
  // no pending sources are modelled, so the request line idles high
  assign bus.int_n = !(mic_reg[`SCR_MIC_MIE] && |(ip_w & ie_w & ~ius_w));
  assign mic_o = mic_reg;
  assign recovering_o = busy;
endmodule // scr_dev

// file: scr_host.sv
// host end: wishbone slave that sequences parallel port accesses
`timescale 1ns/1ps
`include "scr_map.svh"
module scr_host #(
  parameter int GAP_CYC = `SCR_CYCLE_REC_CYC,
  parameter int RST_GAP_CYC = `SCR_RESET_REC_CYC,
  parameter int STROBE_CYC = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  scr_if.host bus
);
  typedef enum logic [1:0] {SCR_IDLE, SCR_STROBE, SCR_GAP} scr_st_e;
  scr_st_e st_reg;
  logic [7:0] cnt_reg; // strobe / gap counter
  logic [7:0] wdata_reg; // byte to write
  logic [7:0] rdata_reg; // captured read byte
  logic [4:0] cmd_reg; // {op, unused, chan_a, data_sel}
  logic start_reg; // one-shot go
  logic did_read_reg; // first read done
  logic ack_reg;
  logic rd_n_reg, wr_n_reg, ia_n_reg;
  // counts the sequencer cannot serve are refused at elaboration
  if (GAP_CYC < `SCR_CYCLE_REC_PCLK || RST_GAP_CYC < `SCR_RESET_REC_PCLK
    || STROBE_CYC < 1 || RST_GAP_CYC > 255 || GAP_CYC > 255
    || STROBE_CYC > 255)
  begin : g_bad_timing
    $error("bad host timing parameters");
  end
  // bus decode
  wire req = wb_cyc_i && wb_stb_i && !ack_reg;
  wire wr_cmd = req && wb_we_i && wb_adr_i == `SCR_WB_CMD && wb_sel_i[0];
  wire wr_wd = req && wb_we_i && wb_adr_i == `SCR_WB_WDATA && wb_sel_i[0];
  wire busy = st_reg != SCR_IDLE || start_reg;
  scr_pkg::scr_op_e op;
  assign op = scr_pkg::scr_op_e'(cmd_reg[4:3]);
  // a hardware reset or any write with bit 7 or 6 set takes the long gap
  wire long_gap = op == scr_pkg::SCR_OP_HWRESET ||
    (op == scr_pkg::SCR_OP_WRITE && wdata_reg[7:6] != 2'b00);
  // wishbone registers, ack one cycle after the request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
      wdata_reg <= 8'h00;
      cmd_reg <= 5'h00;
      start_reg <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      ack_reg <= req;
      start_reg <= wr_cmd && !busy;
      if (wr_wd && !busy)
        wdata_reg <= wb_dat_i[7:0];
      if (wr_cmd && !busy)
        cmd_reg <= wb_dat_i[4:0];
      if (req && !wb_we_i)
        wb_dat_o <= (wb_adr_i == `SCR_WB_STATUS) ?
          {30'h0, did_read_reg, busy} :
          (wb_adr_i == `SCR_WB_RDATA) ? {24'h0, rdata_reg} : 32'h0;
    end
  end
  // port sequencer: strobe, then recovery gap
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_reg <= SCR_IDLE;
      cnt_reg <= 8'h00;
      rd_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
      ia_n_reg <= 1'b1;
      rdata_reg <= 8'h00;
      did_read_reg <= 1'b0;
    end
    else
    begin
      unique case (st_reg)
        SCR_IDLE:
        begin
          if (start_reg)
          begin
            st_reg <= SCR_STROBE;
            cnt_reg <= 8'(STROBE_CYC);
            rd_n_reg <= !(op != scr_pkg::SCR_OP_WRITE);
            // both strobes low is a hardware reset
            wr_n_reg <= !(op == scr_pkg::SCR_OP_WRITE ||
              op == scr_pkg::SCR_OP_HWRESET);
            ia_n_reg <= op != scr_pkg::SCR_OP_INTACK;
          end
        end
        SCR_STROBE:
        begin
          if (cnt_reg == 8'h01)
          begin
            st_reg <= SCR_GAP;
            cnt_reg <= long_gap ? 8'(RST_GAP_CYC) : 8'(GAP_CYC);
            rd_n_reg <= 1'b1;
            wr_n_reg <= 1'b1;
            ia_n_reg <= 1'b1;
            if (!rd_n_reg && !bus.dev_d_oe_n)
              rdata_reg <= bus.dev_d;
            if (op == scr_pkg::SCR_OP_READ)
              did_read_reg <= 1'b1;
          end
          else
            cnt_reg <= cnt_reg - 8'h01;
        end
        SCR_GAP:
        begin
          if (cnt_reg == 8'h01)
            st_reg <= SCR_IDLE;
          else
            cnt_reg <= cnt_reg - 8'h01;
        end
        default:
          st_reg <= SCR_IDLE;
      endcase
    end
  end
  // pins; software sequencing
  // bit five is masked here
  assign bus.rd_n = rd_n_reg;
  assign bus.wr_n = wr_n_reg;
  assign bus.intack_n = ia_n_reg;
  assign bus.ce_n = rd_n_reg && wr_n_reg;
  assign bus.chan_a = cmd_reg[1];
  assign bus.data_sel = cmd_reg[0];
  assign bus.host_d = wdata_reg & 8'hDF;
  assign wb_ack_o = ack_reg;
endmodule // scr_host

// file: scr_if.sv
// parallel register port joining host and controller
`timescale 1ns/1ps
interface scr_if;
  logic rd_n; // read strobe, low active
  logic wr_n; // write strobe, low active
  logic ce_n; // chip enable, low active
  logic chan_a; // 1 selects channel a
  logic data_sel; // 1 data, 0 control
  logic intack_n; // interrupt acknowledge, low active
  logic [7:0] host_d; // data driven by host
  logic [7:0] dev_d; // data driven by device
  logic dev_d_oe_n; // device output enable, low drives
  logic int_n; // interrupt request, low active
  modport dev (
    input rd_n, wr_n, ce_n, chan_a, data_sel, intack_n, host_d,
    output dev_d, dev_d_oe_n, int_n
  );
  modport host (
    output rd_n, wr_n, ce_n, chan_a, data_sel, intack_n, host_d,
    input dev_d, dev_d_oe_n, int_n
  );
endinterface

// file: scr_map.svh
// register offsets, command codes, reset values and timing counts
`ifndef SCR_MAP_SVH
`define SCR_MAP_SVH
// register pointer values
`define SCR_REG_CMD 4'h0
`define SCR_REG_IRQDMA 4'h1
`define SCR_REG_VECTOR 4'h2
`define SCR_REG_RXCTL 4'h3
`define SCR_REG_TXCTL 4'h5
`define SCR_REG_MIC 4'h9
`define SCR_REG_MISCCLK 4'hE
`define SCR_REG_EXTIE 4'hF
// master interrupt control fields
`define SCR_MIC_RST_A 7
`define SCR_MIC_RST_B 6
`define SCR_MIC_UNUSED 5
`define SCR_MIC_NO_VECTOR 1
`define SCR_MIC_MIE 3
`define SCR_MIC_FULL_RESET 8'hC0
`define SCR_MIC_MODE_MASK 8'h1F
// command register codes
`define SCR_CMD_RST_TXCRC 8'h80
`define SCR_CMD_RST_EXTSTAT 8'h10
`define SCR_CMD_PTR_MASK 8'h07
`define SCR_CMD_PTR_HI 8'h08
// enable bits
`define SCR_RX_ENABLE 0
`define SCR_TX_ENABLE 3
`define SCR_TX_DTR 7
`define SCR_TX_RTS 1
`define SCR_BRG_ENABLE 0
// reset values
`define SCR_EXTIE_RST 8'hF8
`define SCR_MISCCLK_RST 8'h20
`define SCR_VECTOR_RST 8'h00
// timing
`define SCR_CLK_MHZ 20
`define SCR_PCLK_NS 50
`define SCR_CYCLE_REC_PCLK 6
`define SCR_RESET_REC_PCLK 11
// host side timing in own clock cycles (same clock as device pclk)
`define SCR_CYCLE_REC_CYC ((`SCR_CYCLE_REC_PCLK*`SCR_PCLK_NS+49)/50)
`define SCR_RESET_REC_CYC ((`SCR_RESET_REC_PCLK*`SCR_PCLK_NS+49)/50)
// host controller wishbone offsets
`define SCR_WB_CMD 4'h0
`define SCR_WB_WDATA 4'h4
`define SCR_WB_STATUS 4'h8
`define SCR_WB_RDATA 4'hC
`endif

// file: scr_pkg.sv
// types used by the host end and the bench
package scr_pkg;
  typedef enum logic [1:0] {
    SCR_OP_WRITE,
    SCR_OP_READ,
    SCR_OP_HWRESET,
    SCR_OP_INTACK
  } scr_op_e;
  typedef logic [7:0] scr_byte_t;
endpackage

// file: scr_props.sv
// concurrent checks on the parallel port and controller outputs
`timescale 1ns/1ps
module scr_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic ce_n,
  input wire logic intack_n,
  input wire logic [7:0] host_d,
  input wire logic dev_d_oe_n,
  input wire logic [1:0] rx_en_o,
  input wire logic [1:0] tx_en_o,
  input wire logic [1:0] txd_o,
  input wire logic [1:0] rts_n_o,
  input wire logic [1:0] dtr_n_o,
  input wire logic [1:0] crc_clr_o,
  input wire logic [7:0] mic_o,
  input wire logic recovering_o
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // both strobes low together is the hardware reset request
  wire hw_rst = !rd_n && !wr_n;
  a_unused_bit_zero: assert property (
    mic_o[5] == 1'b0 && (wr_n || !host_d[5]))
    else $error("bit five seen set");
  a_cmd_not_kept: assert property (mic_o[7:6] == 2'h0)
    else $error("reset command bits stored");
  a_txd_marking: assert property (txd_o == 2'h3)
    else $error("serial output not marking");
  a_hw_reset_clear: assert property (
    hw_rst |-> ##[1:2] (mic_o == 8'h00 && rx_en_o == 2'h0 &&
    tx_en_o == 2'h0 && rts_n_o == 2'h3 && dtr_n_o == 2'h3))
    else $error("hardware reset left state behind");
  a_reset_recovery: assert property (
    hw_rst |-> ##[1:2] recovering_o)
    else $error("no recovery after hardware reset");
  a_recovery_length: assert property (
    $rose(recovering_o) |-> recovering_o [*6])
    else $error("recovery shorter than six cycles");
  a_access_spacing: assert property (
    $fell(ce_n) |-> !recovering_o)
    else $error("access started inside recovery");
  a_write_starts_recov: assert property (
    $fell(wr_n) && rd_n && !ce_n && !recovering_o |=> recovering_o)
    else $error("write did not start recovery");
  a_write_refused: assert property (
    $fell(wr_n) && rd_n && !ce_n && recovering_o |=>
    $stable(mic_o) && $stable(rx_en_o) && $stable(tx_en_o))
    else $error("write honoured during recovery");
  a_crc_cause: assert property (crc_clr_o != 2'h0 |->
    $past(host_d) == 8'h80 && $past(wr_n) == 1'b0)
    else $error("crc reset without its command");
  a_intack_no_vector: assert property (
    !intack_n && mic_o[1] |-> dev_d_oe_n)
    else $error("vector driven in no vector mode");
  a_intack_vector: assert property (
    !intack_n && !rd_n && $past(rd_n) == 1'b0 && !mic_o[1] |->
    !dev_d_oe_n)
    else $error("no vector driven on acknowledge");
  // main scenarios seen at least once
  c_hw_reset: cover property (hw_rst);
  c_intack: cover property (!intack_n && !rd_n);
  c_crc_pulse: cover property (crc_clr_o != 2'h0);
endmodule // scr_props

// file: serial_ctrl_reset_and_init_tb.sv
// self-checking bench joining the host end and the controller end
`timescale 1ns/1ps
`include "scr_map.svh"
// compare, count and report a mismatch at once
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  err_count++; $display("unexpected at %0t: got %h exp %h", $time, g, e); \
  end end
module serial_ctrl_reset_and_init_tb;
  logic clk_i = 1'b0; // 20 MHz system clock
  logic rst_i = 1'b1; // synchronous, high
  logic wb_cyc = 1'b0; // wishbone request lines
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [3:0] wb_adr = 4'h0;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_wdata = 32'h0;
  logic [31:0] wb_rdata;
  logic wb_ack;
  logic [1:0] rx_en, tx_en, txd, rts_n, dtr_n, crc_clr; // per channel
  logic [1:0] crc_seen = 2'h0; // sticky, pulse is only one cycle
  logic [7:0] mic;
  logic recovering;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  scr_if bus_if ();
  scr_host scr_host_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_wdata), .wb_dat_o(wb_rdata), .wb_ack_o(wb_ack), .bus(bus_if));
  scr_dev scr_dev_inst (.clk_i(clk_i), .rst_i(rst_i), .bus(bus_if),
    .rx_en_o(rx_en), .tx_en_o(tx_en), .txd_o(txd), .rts_n_o(rts_n),
    .dtr_n_o(dtr_n), .crc_clr_o(crc_clr), .mic_o(mic),
    .recovering_o(recovering));
  scr_props scr_props_inst (.clk_i(clk_i), .rst_i(rst_i),
    .rd_n(bus_if.rd_n), .wr_n(bus_if.wr_n), .ce_n(bus_if.ce_n),
    .intack_n(bus_if.intack_n), .host_d(bus_if.host_d),
    .dev_d_oe_n(bus_if.dev_d_oe_n), .rx_en_o(rx_en), .tx_en_o(tx_en),
    .txd_o(txd), .rts_n_o(rts_n), .dtr_n_o(dtr_n), .crc_clr_o(crc_clr),
    .mic_o(mic), .recovering_o(recovering));
  // free running clock
  always #25 clk_i = ~clk_i;
  // remember any crc reset pulse
  always @(posedge clk_i) crc_seen <= crc_seen | crc_clr;
  // verdict and end of run
  task automatic stop_test();
    if (err_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // hang guard, well above the several hundred cycles the run needs
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_count++;
      stop_test();
    end
  end
  // one classic wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_sel <= 4'hF;
    wb_adr <= a;
    wb_wdata <= d;
    do @(posedge clk_i); while (wb_ack !== 1'b1);
    q = wb_rdata;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    wb_sel <= 4'h0;
  endtask
  // one port access through the host end, polled until idle
  task automatic dop(input scr_pkg::scr_op_e op, input logic a,
    input logic [7:0] v);
    logic [31:0] q;
    wb(1'b1, `SCR_WB_WDATA, {24'h0, v}, q);
    wb(1'b1, `SCR_WB_CMD, {27'h0, op, 1'b0, a, 1'b0}, q);
    do wb(1'b0, `SCR_WB_STATUS, 32'h0, q);
    while (q[0] !== 1'b0);
  endtask
  // control register write: pointer first, then the value
  task automatic wreg(input logic a, input logic [3:0] r,
    input logic [7:0] v);
    dop(scr_pkg::SCR_OP_WRITE, a, {4'h0, r});
    dop(scr_pkg::SCR_OP_WRITE, a, v);
  endtask
  // main sequence
  initial
  begin
    logic [31:0] q;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    `CHK({mic, rx_en, tx_en, txd, rts_n, dtr_n}, 18'h0003F)
    repeat (12) @(posedge clk_i);
    // pointer left at 3 must be dropped by the read
    dop(scr_pkg::SCR_OP_WRITE, 1'b1, 8'h03);
    dop(scr_pkg::SCR_OP_READ, 1'b1, 8'h00);
    wb(1'b0, `SCR_WB_STATUS, 32'h0, q);
    `CHK(q[1], 1'b1)
    wreg(1'b1, `SCR_REG_MIC, 8'h22);
    `CHK({mic, rx_en}, 10'h008)
    wreg(1'b1, `SCR_REG_VECTOR, 8'h5A);
    dop(scr_pkg::SCR_OP_INTACK, 1'b1, 8'h00);
    wb(1'b0, `SCR_WB_RDATA, 32'h0, q);
    `CHK(q, 32'h0)
    wreg(1'b1, `SCR_REG_MIC, 8'h00);
    dop(scr_pkg::SCR_OP_INTACK, 1'b1, 8'h00);
    wb(1'b0, `SCR_WB_RDATA, 32'h0, q);
    `CHK(q, 32'h5A)
    // modes first, enables after
    wreg(1'b1, `SCR_REG_RXCTL, 8'hC0);
    wreg(1'b1, `SCR_REG_TXCTL, 8'h60);
    `CHK({rx_en, tx_en}, 4'h0)
    wreg(1'b1, `SCR_REG_RXCTL, 8'hC1);
    wreg(1'b1, `SCR_REG_TXCTL, 8'hEA);
    wreg(1'b0, `SCR_REG_RXCTL, 8'hC1);
    `CHK({rx_en, tx_en, rts_n, dtr_n}, 8'hE5)
    dop(scr_pkg::SCR_OP_WRITE, 1'b1, `SCR_CMD_RST_TXCRC);
    `CHK(crc_seen, 2'h2)
    wreg(1'b1, `SCR_REG_EXTIE, `SCR_EXTIE_RST);
    dop(scr_pkg::SCR_OP_WRITE, 1'b1, `SCR_CMD_RST_EXTSTAT);
    dop(scr_pkg::SCR_OP_WRITE, 1'b1, `SCR_CMD_RST_EXTSTAT);
    wreg(1'b1, `SCR_REG_MIC, 8'h0A);
    `CHK(mic, 8'h0A)
    // channel a reset keeps mode bits and channel b
    wreg(1'b1, `SCR_REG_MIC, 8'h8A);
    `CHK({mic, rx_en, tx_en, rts_n, dtr_n}, 16'h0A4F)
    wreg(1'b1, `SCR_REG_MIC, 8'h0A);
    `CHK({rx_en, tx_en}, 4'h4)
    wreg(1'b1, `SCR_REG_MIC, 8'h4A);
    `CHK({rx_en, rts_n}, 4'h3)
    // software full reset
    wreg(1'b1, `SCR_REG_RXCTL, 8'hC1);
    wreg(1'b1, `SCR_REG_MIC, `SCR_MIC_FULL_RESET);
    `CHK({mic, rx_en, tx_en}, 12'h000)
    // hardware reset by both strobes
    wreg(1'b1, `SCR_REG_RXCTL, 8'hC1);
    wreg(1'b1, `SCR_REG_MIC, 8'h0A);
    dop(scr_pkg::SCR_OP_HWRESET, 1'b1, 8'h00);
    `CHK({mic, rx_en}, 10'h000)
    wreg(1'b1, `SCR_REG_MIC, 8'h02);
    `CHK(mic, 8'h02)
    stop_test();
  end
endmodule // serial_ctrl_reset_and_init_tb
